// *** design/bbc_cfg.svh ***
// Purpose: constants for the buck-boost control register bank
// Assumes: byte-wide serial register port, 8-bit address
// Notes: offsets, field positions, reset values and timing counts
`ifndef BBC_CFG_SVH
`define BBC_CFG_SVH
`define BBC_ADDR_ENA 8'h40
`define BBC_ADDR_CFG 8'h41
`define BBC_ADDR_RDBK 8'h3f
`define BBC_ENA_WMASK 8'h03
`define BBC_CFG_WMASK 8'h9f
`define BBC_RDBK_MASK 8'h3f
`define BBC_ENA_RST 8'h00
`define BBC_CFG_RST 8'h00
`define BBC_DSC_RST 1'b1
`define BBC_SEQ_LSB 5
`define BBC_SEQ_MSB 7
`define BBC_EN_LSB 0
`define BBC_EN_MSB 1
`define BBC_LOOKUP_BIT 7
`define BBC_EMI_BIT 4
`define BBC_ACT_BIT 3
`define BBC_RAMP_BIT 2
`define BBC_TOPO_BIT 1
`define BBC_PSV_BIT 0
`define BBC_CLK_HZ 50000000
`define BBC_RAMP_US 20
`define BBC_RAMP_CYC ((`BBC_RAMP_US * `BBC_CLK_HZ) / 1000000)
`define BBC_EDGE_SLOW 3
`endif

// *** design/bbc_pkg.sv ***
// Purpose: types for the buck-boost control register bank
// Assumes: constants live in bbc_cfg.svh
// Notes: sequence slot and enable-select encodings
package bbc_pkg;
  typedef enum logic [2:0] {
    BBC_SEQ_OFF = 3'h0,
    BBC_SEQ_RSV1 = 3'h1,
    BBC_SEQ_AT0 = 3'h2,
    BBC_SEQ_AT25 = 3'h3,
    BBC_SEQ_AT50 = 3'h4,
    BBC_SEQ_RSV5 = 3'h5,
    BBC_SEQ_RSV6 = 3'h6,
    BBC_SEQ_SW = 3'h7
  } bbc_seq_t;
  typedef enum logic [1:0] {
    BBC_EN_OFF = 2'h0,
    BBC_EN_ON = 2'h1,
    BBC_EN_PIN = 2'h2,
    BBC_EN_RSV = 2'h3
  } bbc_en_t;
  typedef enum logic [1:0] {
    BBC_RAMP_IDLE,
    BBC_RAMP_WAIT,
    BBC_RAMP_STEP
  } bbc_ramp_st_t;
endpackage

// *** design/bbc_ramp.sv ***
// Purpose: voltage ramp stepper for the buck-boost output setting
// Assumes: target code arrives from logic on sys_clk
// Notes: only upward moves are stepped; downward moves apply at once
`include "bbc_cfg.svh"
module bbc_ramp
  import bbc_pkg::*;
#(
  parameter int VW = 6,
  parameter int STEP_CYC = `BBC_RAMP_CYC
) (
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ramp_en, // Step upward changes
  input wire logic [VW-1:0] target, // Requested voltage code
  output logic [VW-1:0] applied // Code handed to the regulator
);
  localparam int CW = $clog2(STEP_CYC + 1);
  bbc_ramp_st_t st_q, st_d;
  logic [VW-1:0] v_q, v_d;
  logic [CW-1:0] cnt_q, cnt_d;

  // Next-state: jump down or when ramp is off, else one step per period
  always_comb begin
    st_d = st_q;
    v_d = v_q;
    cnt_d = cnt_q;
    case (st_q)
      BBC_RAMP_IDLE: begin
        if (target <= v_q || !ramp_en) begin
          v_d = target;
        end else begin
          // Load and step edges count toward the period; STEP_CYC must be 2 or more
          cnt_d = CW'(STEP_CYC - 2);
          st_d = BBC_RAMP_WAIT;
        end
      end
      BBC_RAMP_WAIT: begin
        if (!ramp_en || target <= v_q) begin
          v_d = target;
          st_d = BBC_RAMP_IDLE;
        end else if (cnt_q == '0) begin
          st_d = BBC_RAMP_STEP;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      BBC_RAMP_STEP: begin
        if (!ramp_en || target <= v_q) begin
          v_d = target;
          st_d = BBC_RAMP_IDLE;
        end else begin
          v_d = v_q + VW'(1);
          // Reload here so back-to-back steps keep the exact period
          if (target > v_d) begin
            cnt_d = CW'(STEP_CYC - 2);
            st_d = BBC_RAMP_WAIT;
          end else begin
            st_d = BBC_RAMP_IDLE;
          end
        end
      end
      default: st_d = BBC_RAMP_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= BBC_RAMP_IDLE;
      v_q <= '0;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      v_q <= v_d;
      cnt_q <= cnt_d;
    end
  end

  assign applied = v_q;
endmodule

// *** design/bbc_regs.sv ***
// Purpose: buck-boost control register bank with enable sequencing
// Assumes: serial interface delivers byte reads and writes as strobes
// Notes: analog regulator outside; this bank drives its control levels
`include "bbc_cfg.svh"
module bbc_regs
  import bbc_pkg::*;
#(
  parameter int VW = 6,
  parameter int RAMP_CYC = `BBC_RAMP_CYC
) (
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rst_n, // Async hard reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data, registered
  input wire logic [2:0] seq_strap, // Sequence slot, fixed by factory
  input wire logic [1:0] boot_phase, // Boot delay: 0,1,2 = 0/25/50%, 3 = 100%
  input wire logic pin_enable, // Selected multipurpose pin level (async)
  input wire logic [VW-1:0] buck3_sel_code, // Buck3 selected voltage code
  input wire logic [VW-1:0] bb_vset, // Requested buck-boost voltage code
  input wire logic shutdown_mode, // Device in shutdown or off mode
  output logic bb_enable, // Regulator enable
  output logic bb_active_discharge, // Active discharge on
  output logic bb_passive_discharge, // Passive discharge on
  output logic bb_current_table_override, // Peak current from set fields
  output logic bb_slow_edge_mode, // Edges slowed by BBC_EDGE_SLOW
  output logic bb_topology_select, // Buck-only when high
  output logic [VW-1:0] bb_vset_applied // Ramped voltage code
);
  logic [7:0] ena_q, ena_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] seq_q, seq_d;
  logic strap_done_q, strap_done_d;
  logic [2:0] pin_sync_q, pin_sync_d;
  logic pin_q, pin_d;
  logic en_d, en_q, act_d, act_q, psv_d, psv_q;
  bbc_seq_t seq;
  bbc_en_t en_sel;

  // Strap caught on the first clock after reset release
  always_comb begin
    seq_d = seq_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      seq_d = seq_strap;
    end
  end

  // Strap flops; the slot is frozen until the next hard reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= 3'h0;
      strap_done_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      strap_done_q <= strap_done_d;
    end
  end

  // Register writes; only documented bits are stored
  always_comb begin
    ena_d = ena_q;
    cfg_d = cfg_q;
    if (reg_wr) begin
      if (reg_addr == `BBC_ADDR_ENA) begin
        ena_d = reg_wdata & `BBC_ENA_WMASK;
      end else if (reg_addr == `BBC_ADDR_CFG) begin
        cfg_d = reg_wdata & `BBC_CFG_WMASK;
      end
    end
  end

  // Register flops; hard reset clears the bank
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ena_q <= `BBC_ENA_RST;
      cfg_q <= `BBC_CFG_RST;
    end else begin
      ena_q <= ena_d;
      cfg_q <= cfg_d;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `BBC_ADDR_ENA: begin
          rdata_d = ena_q;
          rdata_d[`BBC_SEQ_MSB:`BBC_SEQ_LSB] = seq_q;
        end
        `BBC_ADDR_CFG: rdata_d = cfg_q;
        `BBC_ADDR_RDBK: begin
          rdata_d = {2'h0, buck3_sel_code} & `BBC_RDBK_MASK;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data flop; holds between reads so a slow master can fetch it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pin filter: a change counts when stages two and three agree
  always_comb begin
    // Shift in the raw pin; stage one may be metastable
    pin_sync_d = {pin_sync_q[1:0], pin_enable};
    pin_d = pin_q;
    if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_d = pin_sync_q[2];
    end
  end

  // Filter flops; stage one is read only by stage two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 3'h0;
      pin_q <= 1'b0;
    end else begin
      pin_sync_q <= pin_sync_d;
      pin_q <= pin_d;
    end
  end

  assign seq = bbc_seq_t'(seq_q);
  assign en_sel = bbc_en_t'(ena_q[`BBC_EN_MSB:`BBC_EN_LSB]);

  // Enable decode from slot, boot progress and software field
  always_comb begin
    en_d = 1'b0;
    case (seq)
      BBC_SEQ_AT0: en_d = 1'b1;
      BBC_SEQ_AT25: en_d = (boot_phase >= 2'h1);
      BBC_SEQ_AT50: en_d = (boot_phase >= 2'h2);
      BBC_SEQ_SW: begin
        if (boot_phase == 2'h3) begin
          case (en_sel)
            BBC_EN_ON: en_d = 1'b1;
            BBC_EN_PIN: en_d = pin_q;
            default: en_d = 1'b0;
          endcase
        end
      end
      default: en_d = 1'b0;
    endcase
    act_d = shutdown_mode || (cfg_q[`BBC_ACT_BIT] && !en_d);
    psv_d = shutdown_mode || (cfg_q[`BBC_PSV_BIT] && !en_d);
  end

  // Output flops; both discharges stay on through hard reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      act_q <= `BBC_DSC_RST;
      psv_q <= `BBC_DSC_RST;
    end else begin
      en_q <= en_d;
      act_q <= act_d;
      psv_q <= psv_d;
    end
  end

  // Control levels straight from flops, free of decode glitches
  assign reg_rdata = rdata_q;
  assign bb_enable = en_q;
  assign bb_active_discharge = act_q;
  assign bb_passive_discharge = psv_q;
  assign bb_current_table_override = cfg_q[`BBC_LOOKUP_BIT];
  assign bb_slow_edge_mode = cfg_q[`BBC_EMI_BIT];
  assign bb_topology_select = cfg_q[`BBC_TOPO_BIT];

  bbc_ramp #(
    .VW(VW),
    .STEP_CYC(RAMP_CYC)
  ) u_ramp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ramp_en(cfg_q[`BBC_RAMP_BIT]),
    .target(bb_vset),
    .applied(bb_vset_applied)
  );
endmodule

// *** test/bbc_regs_asserts.sv ***
// Purpose: port checks for the buck-boost register bank
// Assumes: one clock; strap held steady outside reset
// Notes: read data is looked at two edges after its strobe
module bbc_regs_asserts #(
  parameter int VW = 6,
  parameter int RAMP_CYC = 10
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [2:0] seq_strap, // Slot
  input wire logic [VW-1:0] buck3_sel_code, // Buck3 code
  input wire logic shutdown_mode, // Shutdown
  input wire logic bb_enable, // Enable
  input wire logic bb_active_discharge, // Active
  input wire logic bb_passive_discharge, // Passive
  input wire logic bb_current_table_override, // Override
  input wire logic bb_slow_edge_mode // Slow edges
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Config write taken; outputs judged two edges on
  sequence cfg_wr_s;
    reg_wr && reg_addr == 8'h41;
  endsequence
  // Shutdown low long enough to have left the flops
  sequence quiet_s;
    (!shutdown_mode) [*3];
  endsequence
  ovr_bit_a: assert property (cfg_wr_s |-> ##2
    bb_current_table_override == $past(reg_wdata[7], 2)) else $error("override bad");
  slow_edge_a: assert property (cfg_wr_s |-> ##2
    bb_slow_edge_mode == $past(reg_wdata[4], 2)) else $error("slow edge bad");
  rdbk_code_a: assert property (reg_rd && reg_addr == 8'h3f |-> ##2
    reg_rdata == {2'h0, $past(buck3_sel_code, 2)}) else $error("readback bad");
  unused_zero_a: assert property (reg_rd && reg_addr == 8'h41 |-> ##2
    reg_rdata[6:5] == 2'h0) else $error("unused bits set");
  dsc_force_a: assert property ((shutdown_mode) [*3] |->
    bb_active_discharge && bb_passive_discharge) else $error("no discharge");
  dsc_on_a: assert property (quiet_s ##0 bb_enable |->
    !bb_active_discharge && !bb_passive_discharge) else $error("discharge while on");
  slot_on_a: assert property ((seq_strap == 3'h2) [*3] |=> bb_enable)
    else $error("slot on late");
  slot_off_a: assert property ((seq_strap inside {3'h0, 3'h1, 3'h5, 3'h6}) [*3] |=>
    !bb_enable) else $error("slot off bad");
endmodule
bind bbc_regs bbc_regs_asserts #(.VW(VW), .RAMP_CYC(RAMP_CYC)) chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .seq_strap(seq_strap),
  .buck3_sel_code(buck3_sel_code),
  .shutdown_mode(shutdown_mode),
  .bb_enable(bb_enable),
  .bb_active_discharge(bb_active_discharge),
  .bb_passive_discharge(bb_passive_discharge),
  .bb_current_table_override(bb_current_table_override),
  .bb_slow_edge_mode(bb_slow_edge_mode)
);

// *** test/bbc_regs_tb.sv ***
// Purpose: random and corner tests of the buck-boost register bank
// Assumes: ramp count shortened to 10 cycles
// Notes: strap changes only under reset, as in the device
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module bbc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic pin_enable = 1'h0, shutdown_mode = 1'h0, e;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, q;
  logic [2:0] seq_strap = 3'h7;
  logic [1:0] boot_phase = 2'h0;
  logic [5:0] buck3_sel_code = 6'h00, bb_vset = 6'h00, bb_vset_applied;
  logic bb_enable, bb_active_discharge, bb_passive_discharge;
  logic bb_current_table_override, bb_slow_edge_mode, bb_topology_select;
  int n_errors = 0, checks_done = 0, cycles = 0, i, p;
  localparam int RAMP = 10;
  bbc_regs #(.RAMP_CYC(RAMP)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .seq_strap(seq_strap), .boot_phase(boot_phase), .pin_enable(pin_enable),
    .buck3_sel_code(buck3_sel_code), .bb_vset(bb_vset), .shutdown_mode(shutdown_mode),
    .bb_enable(bb_enable), .bb_active_discharge(bb_active_discharge),
    .bb_passive_discharge(bb_passive_discharge),
    .bb_current_table_override(bb_current_table_override),
    .bb_slow_edge_mode(bb_slow_edge_mode), .bb_topology_select(bb_topology_select),
    .bb_vset_applied(bb_vset_applied));
  initial forever #10 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard at 5000 cycles, about ten times the roughly 450 cycles used
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    tick(1);
    q = reg_rdata;
  endtask
  // Boot restarts from 0% on every hard reset
  task automatic hard_reset(input logic [2:0] s);
    @(posedge sys_clk);
    rst_n <= 1'h0;
    seq_strap <= s;
    boot_phase <= 2'h0;
    repeat (5) @(posedge sys_clk);
    `CHK("reset dsc", 2'h3, {bb_active_discharge, bb_passive_discharge})
    rst_n <= 1'h1;
    tick(1);
    `CHK("dsc released", 2'h0, {bb_active_discharge, bb_passive_discharge})
  endtask
  function automatic logic exp_en(logic [2:0] s, logic [1:0] ph, logic [1:0] en, logic pin);
    case (s)
      3'h2: return 1'h1;
      3'h3: return ph >= 2'h1;
      3'h4: return ph >= 2'h2;
      3'h7: return ph == 2'h3 && (en == 2'h1 || (en == 2'h2 && pin));
      default: return 1'h0;
    endcase
  endfunction
  initial begin
    void'($urandom(98206));
    hard_reset(3'h7);
    rd(8'h40);
    `CHK("ena reset", 8'he0, q)
    rd(8'h41);
    `CHK("cfg reset", 8'h00, q)
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      wr(8'h41, d);
      rd(8'h41);
      `CHK("cfg read", d & 8'h9f, q)
      `CHK("override", d[7], bb_current_table_override)
      `CHK("slow edge", d[4], bb_slow_edge_mode)
      `CHK("topology", d[1], bb_topology_select)
    end
    $display("config test done");
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      buck3_sel_code <= (i == 0) ? 6'h3f : 6'($urandom);
      wr(8'h3f, 8'h00);
      rd(8'h3f);
      `CHK("readback", {2'h0, buck3_sel_code}, q)
    end
    rd(8'h55);
    `CHK("unmapped", 8'h00, q)
    $display("readback test done");
    @(posedge sys_clk);
    boot_phase <= 2'h3;
    wr(8'h41, 8'h09);
    for (i = 0; i < 8; i++) begin
      d = {6'($urandom), i[1:0]};
      @(posedge sys_clk);
      pin_enable <= i[2];
      wr(8'h40, d);
      rd(8'h40);
      `CHK("ena read", {3'h7, 3'h0, d[1:0]}, q)
      tick(6);
      e = exp_en(3'h7, 2'h3, d[1:0], i[2]);
      `CHK("enable", e, bb_enable)
      `CHK("act dsc", !e, bb_active_discharge)
      `CHK("psv dsc", !e, bb_passive_discharge)
    end
    wr(8'h41, 8'h00);
    tick(3);
    `CHK("off no dsc", 1'h0, bb_active_discharge)
    @(posedge sys_clk);
    shutdown_mode <= 1'h1;
    tick(4);
    `CHK("shutdown dsc", 1'h1, bb_active_discharge & bb_passive_discharge)
    @(posedge sys_clk);
    shutdown_mode <= 1'h0;
    $display("enable test done");
    wr(8'h41, 8'h04);
    @(posedge sys_clk);
    bb_vset <= 6'h03;
    // One code per RAMP cycles, counted from the edge that sees the new target
    tick(RAMP);
    `CHK("ramp hold", 6'h00, bb_vset_applied)
    tick(1);
    `CHK("ramp step", 6'h01, bb_vset_applied)
    tick(RAMP);
    `CHK("ramp period", 6'h02, bb_vset_applied)
    tick(RAMP);
    `CHK("ramp end", 6'h03, bb_vset_applied)
    @(posedge sys_clk);
    bb_vset <= 6'h00;
    tick(3);
    `CHK("ramp down", 6'h00, bb_vset_applied)
    wr(8'h41, 8'h00);
    @(posedge sys_clk);
    bb_vset <= 6'h3c;
    tick(3);
    `CHK("no ramp", 6'h3c, bb_vset_applied)
    $display("ramp test done");
    for (i = 0; i < 8; i++) begin
      hard_reset(i[2:0]);
      for (p = 0; p < 4; p++) begin
        @(posedge sys_clk);
        boot_phase <= p[1:0];
        tick(4);
        `CHK("slot enable", exp_en(i[2:0], p[1:0], 2'h0, 1'h0), bb_enable)
      end
    end
    $display("slot test done");
    stop_test();
  end
endmodule
